// File: hdl/sra_engine.sv
/*
 spi slave register access engine with looping address pointer and write lock.
 assumes spi pins and data ready arrive asynchronously; clk samples them through two flops.
 register storage, read data and lock key sit outside; writes leave as a strobe struct.
*/
// Overview of operation
// - first byte is control: two-bit id, five-bit address, direction; output tri-stated.
// - answer only control bytes whose id matches own, default binary 01.
// - chip select rising edge aborts transfer and returns interface to idle.
// - read starts by shifting out register at control byte address.
// - while select low, next register follows without new control byte.
// - read loop: 00 hold, 01 groups, 10 types default, 11 whole map.
// - serial output changes on serial clock falling edge.
// - write starts at control address, then follows write loop bit.
// - write loop: 0 keeps address, 1 loops over types, default.
// - serial output stays high impedance through a whole write.
// - serial input sampled on serial clock rising edge.
// - write to undefined or read-only address changes nothing, pointer holds.
// - lock key not A5 blocks writes except to lock register 1F.
// - one control byte per transaction; loop continues until select rises.
// - pointer steps to next address in set, wraps at set end.
// - serial input ignored after control byte during reads.
// - width field 01 selects 24-bit register transfers.
// - idle-low mode: after full read, output takes next register msb on last fall.
// - idle-low mode idle clock: data ready falling edge refreshes msb; code only while done_reg, which a full read's last fall clears.
// - idle-high mode: output holds last bit sent after complete read.
// - continuous read behaves alike in both clock idle modes.
`timescale 1ns/10ps
`default_nettype none
`include "sra_defs.svh"
module sra_engine (
   input  wire logic             clk,           // 125 MHz core clock
   input  wire logic             rst,           // async reset, high
   input  wire logic             cs_n_pin,      // chip select, low active
   input  wire logic             sck_pin,       // serial clock from host
   input  wire logic             sdi_pin,       // serial data in
   input  wire logic             data_ready_pin,// data ready pulse, low active
   input  wire logic [1:0]       read_loop,     // read loop setting
   input  wire logic             write_loop,    // write loop setting
   input  wire logic [1:0]       width_data,    // transfer width field
   input  wire logic [7:0]       lock_key,      // current lock key
   input  wire logic [1:0]       dev_id,        // own device id
   input  wire logic [31:0]      rd_data,       // data of reg at rd_addr
   output logic      [4:0]       rd_addr,       // pointer seen by reader
   output sra_pkg::sra_wr_t      wr_req,        // one-cycle write strobe
   output logic                  sdo_out,       // serial data out value
   output logic                  sdo_oe,        // serial data out enable
   output logic                  busy           // transaction in progress
);
   // two-flop synchronisers for pins
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic [3:0] prev_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 4'hF;
         sync2_reg <= 4'hF;
         prev_reg  <= 4'hF;
      end else begin
         sync1_reg <= {cs_n_pin, sck_pin, sdi_pin, data_ready_pin};
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end
   // edge decode of synchronised pins
   wire logic cs_n    = sync2_reg[3];
   wire logic sck     = sync2_reg[2];
   wire logic sdi     = sync2_reg[1];
   wire logic cs_fall = prev_reg[3] & ~cs_n;
   wire logic cs_rise = ~prev_reg[3] & cs_n;
   wire logic sck_rise = ~prev_reg[2] & sck;
   wire logic sck_fall = prev_reg[2] & ~sck;
   wire logic dr_fall = prev_reg[0] & ~sync2_reg[0];
   // word length from width field
   wire logic [5:0] word_bits = (width_data == `SRA_WIDTH_24) ? 6'd24 :
                                (width_data == 2'h0) ? 6'd16 : 6'd32;
   // state and datapath registers
   sra_pkg::sra_state_t state_reg, state_next;
   logic [5:0]  bit_reg;
   logic [31:0] shift_reg;
   logic [4:0]  addr_reg;
   logic        idle_low_reg;
   logic        done_reg;
   logic [4:0]  rd_addr_reg;
   sra_pkg::sra_wr_t wr_reg;
   logic        sdo_reg;
   logic        oe_reg;
   logic        busy_reg;
   // control byte view of shifted bits
   wire logic [7:0] ctrl_byte = {shift_reg[6:0], sdi};
   sra_pkg::sra_ctrl_t ctrl;
   assign ctrl = ctrl_byte;
   wire logic ctrl_done = (state_reg == sra_pkg::SRA_CTRL) && sck_rise && (bit_reg == 6'd7);
   wire logic id_ok     = (ctrl.dev_id == dev_id);
   // pointer step
   wire logic [1:0] wmode = write_loop ? 2'h2 : 2'h0;
   wire logic [1:0] loop_sel = (state_reg == sra_pkg::SRA_READ) ? read_loop : wmode;
   logic [4:0] step_addr;
   sra_next_addr u_step (
      .cur_addr  (addr_reg),
      .loop_mode (loop_sel),
      .nxt_addr  (step_addr)
   );
   // write decode
   wire logic word_end_w = (state_reg == sra_pkg::SRA_WRITE) && sck_rise && (bit_reg == word_bits - 6'd1);
   wire logic [31:0] wr_word = {shift_reg[30:0], sdi};
   wire logic writable = (addr_reg > `SRA_ADC_LAST_ADDR);
   wire logic unlocked = (lock_key == `SRA_LOCK_KEY) || (addr_reg == `SRA_LOCK_ADDR);
   wire logic wr_ok = word_end_w && writable && unlocked;
   // read decode: msb of current word; left aligned load
   wire logic word_end_r = (state_reg == sra_pkg::SRA_READ) && sck_fall && (bit_reg == word_bits - 6'd1);
   wire logic [31:0] rd_aligned = rd_data << (6'd32 - word_bits);
   // next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         sra_pkg::SRA_IDLE:  if (cs_fall) state_next = sra_pkg::SRA_CTRL;
         sra_pkg::SRA_CTRL:  if (ctrl_done) begin
            state_next = !id_ok ? sra_pkg::SRA_MUTE :
                         ctrl.rd ? sra_pkg::SRA_READ : sra_pkg::SRA_WRITE;
         end
         sra_pkg::SRA_READ:  state_next = sra_pkg::SRA_READ;
         sra_pkg::SRA_WRITE: state_next = sra_pkg::SRA_WRITE;
         sra_pkg::SRA_MUTE:  state_next = sra_pkg::SRA_MUTE;
         default:            state_next = sra_pkg::SRA_IDLE;
      endcase
      if (cs_rise || cs_n) state_next = sra_pkg::SRA_IDLE;
   end
   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) state_reg <= sra_pkg::SRA_IDLE;
      else     state_reg <= state_next;
   end
   // bit counter, shifter and pointer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_reg      <= 6'd0;
         shift_reg    <= 32'h00000000;
         addr_reg     <= 5'h00;
         idle_low_reg <= 1'b0;
         done_reg     <= 1'b0;
      end else if (state_next == sra_pkg::SRA_IDLE) begin
         bit_reg  <= 6'd0;
         done_reg <= 1'b0;
      end else if (state_reg == sra_pkg::SRA_IDLE) begin
         idle_low_reg <= ~sck;                  // clock level at select fall picks mode
         bit_reg      <= 6'd0;
      end else if (state_reg == sra_pkg::SRA_CTRL) begin
         // the control byte is dropped once decoded, so a write word starts from zero
         if (sck_rise) begin
            shift_reg <= ctrl_done ? 32'h00000000 : {shift_reg[30:0], sdi};
            bit_reg   <= ctrl_done ? 6'd0 : bit_reg + 6'd1;
         end
         if (ctrl_done) addr_reg <= ctrl.addr;
      end else if (state_reg == sra_pkg::SRA_WRITE) begin
         if (sck_rise) begin
            shift_reg <= word_end_w ? 32'h00000000 : wr_word;
            bit_reg   <= word_end_w ? 6'd0 : bit_reg + 6'd1;
         end
         if (wr_ok) addr_reg <= step_addr;
      end else if (state_reg == sra_pkg::SRA_READ) begin
         if (sck_fall) begin
            bit_reg  <= word_end_r ? 6'd0 : bit_reg + 6'd1;
            done_reg <= word_end_r;
         end else if (dr_fall) begin
            done_reg <= 1'b0;
         end
         if (word_end_r) addr_reg <= step_addr;
      end
   end
   // serial output: cleared at control byte end, then falling edges only, tri-stated outside reads
   wire logic rd_first = (state_reg == sra_pkg::SRA_CTRL) && ctrl_done && id_ok && ctrl.rd;
   wire logic [5:0] out_idx = 6'd31 - bit_reg;
   wire logic next_bit = rd_aligned[out_idx[4:0]];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sdo_reg     <= 1'b0;
         oe_reg      <= 1'b0;
         rd_addr_reg <= 5'h00;
      end else begin
         oe_reg <= (state_next == sra_pkg::SRA_READ);
         if (ctrl_done) rd_addr_reg <= ctrl.addr;
         else if (word_end_r) rd_addr_reg <= step_addr;
         if (rd_first) begin
            sdo_reg <= 1'b0;
         end else if (state_reg == sra_pkg::SRA_READ) begin
            // the fall that ends a word still carries its lsb; the next fall shows the new msb
            if (word_end_r) begin
               sdo_reg <= next_bit;
            end else if (sck_fall && !done_reg) begin
               sdo_reg <= (bit_reg == 6'd0) ? rd_aligned[31] : next_bit;
            end else if (sck_fall && done_reg) begin
               sdo_reg <= next_bit;
            end else if (dr_fall && done_reg && idle_low_reg && !sck) begin
               sdo_reg <= rd_aligned[31];
            end
         end
      end
   end
   // first bit of word appears at first fall in both idle modes; rd_first only clears sdo_reg
   // idle-high keeps last bit after word end since nothing updates sdo_reg then
   // write strobe and busy
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_reg   <= '0;
         busy_reg <= 1'b0;
      end else begin
         wr_reg.we   <= wr_ok;
         wr_reg.addr <= addr_reg;
         wr_reg.data <= wr_word;
         busy_reg    <= (state_next != sra_pkg::SRA_IDLE);
      end
   end
   assign rd_addr = rd_addr_reg;
   assign wr_req  = wr_reg;
   assign sdo_out = sdo_reg;
   assign sdo_oe  = oe_reg;
   assign busy    = busy_reg;
endmodule : sra_engine
`default_nettype wire

// File: common/sra_defs.svh
/*
 register access engine constants: control byte fields, loop settings, lock key, set bounds.
 assumes inclusion by bare name from package and design files.
*/
`ifndef SRA_DEFS_SVH
`define SRA_DEFS_SVH
`define SRA_DEV_ID_DEFAULT   2'h1
`define SRA_READ_LOOP_RST    2'h2
`define SRA_WRITE_LOOP_RST   1'h1
`define SRA_LOCK_KEY         8'hA5
`define SRA_LOCK_ADDR        5'h1F
`define SRA_ADC_LAST_ADDR    5'h07
`define SRA_MAP_FIRST        5'h00
`define SRA_MAP_LAST         5'h1F
`define SRA_GROUP_SPAN       5'h04
`define SRA_TYPE_SPLIT       5'h08
`define SRA_WIDTH_24         2'h1
`define SRA_CTRL_BITS        4'h8
`define SRA_CLK_NS           8
`endif

// File: common/sra_pkg.sv
/*
 types for the register access engine.
 assumes sra_defs.svh carries the numeric constants.
*/
`include "sra_defs.svh"
package sra_pkg;
   typedef enum logic [2:0] {
      SRA_IDLE  = 3'b000,
      SRA_CTRL  = 3'b001,
      SRA_READ  = 3'b010,
      SRA_WRITE = 3'b011,
      SRA_MUTE  = 3'b100
   } sra_state_t;
   typedef struct packed {
      logic [1:0] dev_id;
      logic [4:0] addr;
      logic       rd;
   } sra_ctrl_t;
   typedef struct packed {
      logic        we;
      logic [4:0]  addr;
      logic [31:0] data;
   } sra_wr_t;
endpackage : sra_pkg

// File: hdl/sra_next_addr.sv
/*
 combinational pointer step: next address within the selected register set.
 assumes set bounds from sra_defs.svh; mode 0 holds, others wrap in their set.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sra_defs.svh"
module sra_next_addr (
   input  wire logic [4:0] cur_addr,    // present pointer
   input  wire logic [1:0] loop_mode,   // 0 hold, 1 group, 2 type, 3 map
   output logic      [4:0] nxt_addr     // pointer after one transfer
);
   // set bounds per loop mode
   wire logic [4:0] grp_first = cur_addr & ~(`SRA_GROUP_SPAN - 5'h01);
   wire logic [4:0] grp_last  = grp_first + `SRA_GROUP_SPAN - 5'h01;
   wire logic [4:0] typ_first = (cur_addr < `SRA_TYPE_SPLIT) ? `SRA_MAP_FIRST : `SRA_TYPE_SPLIT;
   wire logic [4:0] typ_last  = (cur_addr < `SRA_TYPE_SPLIT) ? (`SRA_TYPE_SPLIT - 5'h01) : `SRA_MAP_LAST;
   wire logic [4:0] set_first = (loop_mode == 2'h1) ? grp_first :
                                (loop_mode == 2'h2) ? typ_first : `SRA_MAP_FIRST;
   wire logic [4:0] set_last  = (loop_mode == 2'h1) ? grp_last :
                                (loop_mode == 2'h2) ? typ_last : `SRA_MAP_LAST;
   // step or wrap to set start
   assign nxt_addr = (loop_mode == 2'h0) ? cur_addr :
                     (cur_addr == set_last) ? set_first :
                     cur_addr + 5'h01;
endmodule : sra_next_addr
`default_nettype wire

// File: tb/sra_engine_chk.sv
/* checker for the register access engine: tri-state, id, write-block and edge relations at the ports.
   assumes it is bound to every sra_engine and that the pins are slow against clk. */
`timescale 1ns/10ps
`default_nettype none
module sra_engine_chk (
   input  wire logic             clk,            // core clock
   input  wire logic             rst,            // async reset, high
   input  wire logic             cs_n_pin,       // chip select, low active
   input  wire logic             sck_pin,        // serial clock
   input  wire logic             sdi_pin,        // serial data in
   input  wire logic             data_ready_pin, // data ready, low active
   input  wire logic [1:0]       read_loop,      // read loop setting
   input  wire logic             write_loop,     // write loop setting
   input  wire logic [1:0]       width_data,     // word width field
   input  wire logic [7:0]       lock_key,       // lock key
   input  wire logic [1:0]       dev_id,         // own id
   input  wire logic [31:0]      rd_data,        // read data
   input  wire logic [4:0]       rd_addr,        // pointer
   input  wire sra_pkg::sra_wr_t wr_req,         // write strobe
   input  wire logic             sdo_out,        // serial out value
   input  wire logic             sdo_oe,         // serial out enable
   input  wire logic             busy            // transfer in progress
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [1:0]         sck_d, dr_d;
   logic [3:0]         nrise, age;
   sra_pkg::sra_ctrl_t ctl;
   wire                rise = (sck_d == 2'b01);
   wire                done = (nrise == 4'h8);
   wire                fall = (sck_d == 2'b10) || (dr_d == 2'b10);
   // control clocks seen since select fell, and cycles since the last falling edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nrise <= 4'h0;
         age   <= 4'hF;
      end else begin
         nrise <= cs_n_pin ? 4'h0 : (rise && !done) ? nrise + 4'h1 : nrise;
         age   <= fall ? 4'h0 : (age == 4'hF) ? age : age + 4'h1;
      end
   end
   // pin sampling and control byte capture, no reset needed
   always_ff @(posedge clk) begin
      sck_d <= {sck_d[0], sck_pin};
      dr_d  <= {dr_d[0], data_ready_pin};
      if (rise && !done) ctl <= {ctl[6:0], sdi_pin};
   end
   cs_idle_hiz_a: assert property (cs_n_pin [*6] |-> !sdo_oe)
      else $error("serial out enabled while deselected");
   ctrl_hiz_a: assert property ($rose(sdo_oe) |-> done)
      else $error("serial out enabled during control byte");
   write_hiz_a: assert property (done && !ctl.rd |-> !sdo_oe)
      else $error("serial out enabled in a write");
   id_mute_a: assert property (done && ctl.dev_id != dev_id |-> !sdo_oe && !wr_req.we)
      else $error("foreign id answered");
   read_id_a: assert property ($rose(sdo_oe) |-> ctl.rd && ctl.dev_id == dev_id)
      else $error("output enabled without matching read");
   sdo_edge_a: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_out) |-> age < 4'h8)
      else $error("serial out moved away from a falling edge");
   lock_block_a: assert property (wr_req.we |-> lock_key == 8'hA5 || wr_req.addr == 5'h1F)
      else $error("write passed a locked map");
   ro_block_a: assert property (wr_req.we |-> wr_req.addr > 5'h07 && !ctl.rd)
      else $error("write to a read-only address");
   wr_strobe_a: assert property (wr_req.we |=> !wr_req.we [*8])
      else $error("write strobes too close");
endmodule : sra_engine_chk
bind sra_engine sra_engine_chk u_chk (.clk(clk), .rst(rst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
   .sdi_pin(sdi_pin), .data_ready_pin(data_ready_pin), .read_loop(read_loop), .write_loop(write_loop),
   .width_data(width_data), .lock_key(lock_key), .dev_id(dev_id), .rd_data(rd_data), .rd_addr(rd_addr),
   .wr_req(wr_req), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .busy(busy));
`default_nettype wire

// File: tb/sra_host_model.sv
/* host side of the serial link: one frame per call, control byte then data bits.
   assumes a 125 ns serial clock that stands still between frames. */
`timescale 1ns/10ps
`default_nettype none
module sra_host_model (
   output logic      cs_n_pin, // chip select, low active
   output logic      sck_pin,  // serial clock
   output logic      sdi_pin,  // serial data to the engine
   input  wire logic sdo_out,  // engine serial out
   input  wire logic sdo_oe    // engine drives serial out
);
   logic toggle = 1'b0;
   // a released line reads as a moving pattern, never a held value
   wire  sdo_line = sdo_oe ? sdo_out : toggle;
   always #5 toggle = ~toggle;
   initial begin
      cs_n_pin = 1'b1;
      sck_pin  = 1'b0;
      sdi_pin  = 1'b0;
   end
   // one frame: data set after falling edge, serial out sampled at rising edge
   task automatic xfer(input logic cpol, input logic [7:0] ctrl, input logic [95:0] tx, input int n,
                       output logic [95:0] rx);
      rx = '0;
      sck_pin = cpol;
      #200;
      cs_n_pin = 1'b0;
      #100;
      for (int i = 0; i < n + 8; i++) begin
         sck_pin = 1'b0;
         sdi_pin = (i < 8) ? ctrl[7 - i] : tx[n + 7 - i];
         #62.5;
         sck_pin = 1'b1;
         if (i >= 8) rx = {rx[94:0], sdo_line};
         #62.5;
         sck_pin = cpol;
      end
      #100;
      cs_n_pin = 1'b1;
   endtask : xfer
endmodule : sra_host_model
`default_nettype wire

// File: tb/sra_engine_bench.sv
/* self-checking bench for sra_engine: loop modes, widths, write blocking and abort.
   assumes sra_host_model as the serial host and rd_data built here from the pointer. */
`timescale 1ns/10ps
`default_nettype none
module sra_engine_bench;
   logic             clk = 1'b0, rst = 1'b1, data_ready_pin = 1'b1, write_loop = 1'b1;
   logic             cs_n_pin, sck_pin, sdi_pin, sdo_out, sdo_oe, busy;
   logic [1:0]       read_loop = 2'h2, width_data = 2'h1, dev_id = 2'h1;
   logic [7:0]       lock_key = 8'hA5;
   logic [4:0]       rd_addr;
   logic [95:0]      rx;
   sra_pkg::sra_wr_t wr_req;
   sra_pkg::sra_wr_t wq[$];
   int               n_fail = 0, samples_checked = 0, cyc = 0;
   // register contents, distinct per address
   function automatic logic [31:0] regval(input logic [4:0] a);
      return {a, 3'h6, a, 3'h1, a, 3'h3, a, 3'h5};
   endfunction : regval
   always #4 clk = ~clk;
   sra_engine u_dut (.clk(clk), .rst(rst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .sdi_pin(sdi_pin),
      .data_ready_pin(data_ready_pin), .read_loop(read_loop), .write_loop(write_loop), .width_data(width_data),
      .lock_key(lock_key), .dev_id(dev_id), .rd_data(regval(rd_addr)), .rd_addr(rd_addr), .wr_req(wr_req),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe), .busy(busy));
   sra_host_model u_host (.cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .sdi_pin(sdi_pin), .sdo_out(sdo_out),
      .sdo_oe(sdo_oe));
   // log write strobes and cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (wr_req.we === 1'b1) wq.push_back(wr_req);
      if (cyc == 40000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   // each read loop mode: two words, second from the next address of the set
   task automatic t_read();
      logic [14:0] tbl [4] = '{{2'h0, 2'h1, 1'b0, 5'h05, 5'h05}, {2'h1, 2'h2, 1'b1, 5'h07, 5'h04},
                               {2'h2, 2'h1, 1'b0, 5'h1F, 5'h08}, {2'h3, 2'h3, 1'b1, 5'h1F, 5'h00}};
      int          w;
      logic [31:0] m;
      for (int i = 0; i < 4; i++) begin
         w = (tbl[i][12:11] == 2'h1) ? 24 : 32;
         m = (w == 24) ? 32'h00FFFFFF : 32'hFFFFFFFF;
         @(posedge clk);
         read_loop  <= tbl[i][14:13];
         width_data <= tbl[i][12:11];
         data_ready_pin <= 1'b0;
         repeat (2) @(posedge clk);
         data_ready_pin <= 1'b1;
         u_host.xfer(tbl[i][10], {2'h1, tbl[i][9:5], 1'b1}, '1, 2 * w, rx);
         check(32'(rx >> w) & m, regval(tbl[i][9:5]) & m);
         check(32'(rx) & m, regval(tbl[i][4:0]) & m);
      end
      $display("read loops done");
   endtask : t_read
   task automatic wframe(input logic [7:0] ctrl, input logic [95:0] tx, input int n);
      u_host.xfer(1'b0, ctrl, tx, n, rx);
      repeat (8) @(posedge clk);
   endtask : wframe
   task automatic expect_wr(input logic [4:0] a, input logic [23:0] d);
      sra_pkg::sra_wr_t e;
      e = (wq.size() > 0) ? wq.pop_front() : '0;
      check({27'h0, e.addr}, {27'h0, a});
      check(e.data, {8'h00, d});
   endtask : expect_wr
   // writes: type loop, held pointer, refused targets, abort and lock
   task automatic t_write();
      @(posedge clk);
      width_data <= 2'h1;
      wframe({2'h1, 5'h1E, 1'b0}, {24'h123456, 24'hABCDEF}, 48);
      expect_wr(5'h1E, 24'h123456);
      expect_wr(5'h1F, 24'hABCDEF);
      wframe({2'h1, 5'h07, 1'b0}, {24'h111111, 24'h222222}, 48);
      write_loop <= 1'b0;
      wframe({2'h1, 5'h0A, 1'b0}, {24'h00C0DE, 24'h0BEEF0}, 48);
      expect_wr(5'h0A, 24'h00C0DE);
      expect_wr(5'h0A, 24'h0BEEF0);
      wframe({2'h2, 5'h10, 1'b0}, 24'h222222, 24);
      wframe({2'h1, 5'h0C, 1'b0}, 24'h333333, 12);
      lock_key <= 8'h00;
      wframe({2'h1, 5'h10, 1'b0}, 24'h444444, 24);
      wframe({2'h1, 5'h1F, 1'b0}, 24'h0000A5, 24);
      expect_wr(5'h1F, 24'h0000A5);
      check(wq.size(), 32'h0);
      check({31'h0, busy}, 32'h0);
      $display("writes done");
   endtask : t_write
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_read();
      t_write();
      give_verdict();
   end
endmodule : sra_engine_bench
`default_nettype wire
